// file: smrzod_cfg.svh
// offsets, field positions, reset values and counts of the mode decoder
`ifndef SMRZOD_CFG_SVH
`define SMRZOD_CFG_SVH
`define SMRZOD_ADR_ZERO    8'h00
`define SMRZOD_ADR_ONE     8'h04
`define SMRZOD_ADR_STAT    8'h08
`define SMRZOD_ADR_CTRL    8'h0c
`define SMRZOD_Z_BL_HI     1
`define SMRZOD_Z_BL_LO     0
`define SMRZOD_Z_CD2       2
`define SMRZOD_Z_BT        3
`define SMRZOD_Z_CD_HI     6
`define SMRZOD_Z_CD_LO     4
`define SMRZOD_Z_TM        7
`define SMRZOD_Z_DLLRST    8
`define SMRZOD_Z_WR_HI     11
`define SMRZOD_Z_WR_LO     9
`define SMRZOD_Z_PDX       12
`define SMRZOD_O_DLLDIS    0
`define SMRZOD_O_LAT_HI    4
`define SMRZOD_O_LAT_LO    3
`define SMRZOD_O_WLVL      7
`define SMRZOD_O_QOFF      12
`define SMRZOD_OTF_BIT     12
`define SMRZOD_MR_RST      13'h0000
`define SMRZOD_CTRL_RST    10'h0a6
`define SMRZOD_CD_BASE     6'h04
`define SMRZOD_WR_BASE     6'h04
`define SMRZOD_WR_ZERO     6'h10
`define SMRZOD_LOCK_CK     10'h200
`define SMRZOD_LAST_BEAT   3'h7
`define SMRZOD_CHOP_LAST   3'h3
`endif

// file: smrzod_pkg.sv
// types shared by the mode register decoder
package smrzod_pkg;
   typedef struct packed {
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  ba;
      logic [12:0] addr;
   } smrzod_cmd_t;

   typedef enum logic [1:0] {
      SMRZOD_BL_EIGHT = 2'b00,
      SMRZOD_BL_OTF   = 2'b01,
      SMRZOD_BL_CHOP  = 2'b10,
      SMRZOD_BL_RSVD  = 2'b11
   } smrzod_bl_t;

   typedef enum logic [1:0] {
      SMRZOD_IDLE  = 2'b00,
      SMRZOD_WAIT  = 2'b01,
      SMRZOD_BURST = 2'b10
   } smrzod_state_t;
endpackage : smrzod_pkg

// file: smrzod_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module smrzod_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta  <= '0;
         q_out <= '0;
      end
      else
      begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule : smrzod_sync
`default_nettype wire

// file: smrzod_decode.sv
// mode register zero/one decoder with burst order and read delay logic
`timescale 1ns/100ps
`default_nettype none
`include "smrzod_cfg.svh"
module smrzod_decode (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        ck_in,
   input  wire logic        cke_in,
   input  wire logic        cs_n_in,
   input  wire logic        ras_n_in,
   input  wire logic        cas_n_in,
   input  wire logic        we_n_in,
   input  wire logic [2:0]  ba_in,
   input  wire logic [12:0] addr_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output var  logic [31:0] wb_dat_out,
   output var  logic        wb_ack_out,
   output var  logic        beat_valid_out,
   output var  logic [2:0]  beat_col_out,
   output var  logic        beat_write_out,
   output var  logic        beat_drive_out,
   output var  logic        beat_care_out,
   output var  logic        write_ref_out,
   output var  logic        dll_running_out,
   output var  logic        dll_locked_out,
   output var  logic        self_refresh_out
);
   smrzod_pkg::smrzod_cmd_t   pins;
   smrzod_pkg::smrzod_cmd_t   cmd;
   smrzod_pkg::smrzod_state_t state;
   logic        ck_s;
   logic        ck_d;
   logic [12:0] mode_reg_zero;
   logic [12:0] mode_reg_one;
   logic [9:0]  ctrl;
   logic        dll_rst_pend;
   logic [9:0]  lock_cnt;
   logic        self_ref;
   logic        pdown;
   logic [5:0]  wait_cnt;
   logic [2:0]  beat_idx;
   logic [2:0]  start_col;
   logic        is_write;
   logic        chop;
   logic        chop_fixed;
   logic        interleave;

   assign pins = '{cke: cke_in, cs_n: cs_n_in, ras_n: ras_n_in,
                   cas_n: cas_n_in, we_n: we_n_in, ba: ba_in,
                   addr: addr_in};

   smrzod_sync #(
      .W($bits(smrzod_pkg::smrzod_cmd_t) + 1)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .d_in       ({ck_in, pins}),
      .q_out      ({ck_s, cmd})
   );

   // link clock edges as seen from the system clock
   wire ck_rise = ck_s & ~ck_d;
   wire ck_fall = ~ck_s & ck_d;
   wire ck_edge = ck_rise | ck_fall;

   wire cmd_sel   = ck_rise & ~cmd.cs_n;
   wire is_mrs    = cmd_sel & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
   wire is_ref    = cmd_sel & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
   wire is_rd     = cmd_sel & cmd.ras_n & ~cmd.cas_n & cmd.we_n;
   wire is_wr     = cmd_sel & cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
   wire load_zero = is_mrs & (cmd.ba == 3'h0);
   wire load_one  = is_mrs & (cmd.ba == 3'h1);

   // decoded fields of register zero
   wire [1:0] bl_code   = mode_reg_zero[`SMRZOD_Z_BL_HI:`SMRZOD_Z_BL_LO];
   wire       bl_otf    = bl_code == smrzod_pkg::SMRZOD_BL_OTF;
   wire       bl_chop   = bl_code == smrzod_pkg::SMRZOD_BL_CHOP;
   wire       bt_ilv    = mode_reg_zero[`SMRZOD_Z_BT];
   wire [3:0] cd_code   = {mode_reg_zero[`SMRZOD_Z_CD2],
                           mode_reg_zero[`SMRZOD_Z_CD_HI:`SMRZOD_Z_CD_LO]};
   wire [5:0] col_delay = `SMRZOD_CD_BASE + {2'b00, cd_code};
   wire [2:0] wr_code   = mode_reg_zero[`SMRZOD_Z_WR_HI:`SMRZOD_Z_WR_LO];
   wire [5:0] wr_cycles = (wr_code == 3'h0) ? `SMRZOD_WR_ZERO :
                          wr_code[2] ? {2'b00, wr_code, 1'b0} :
                          `SMRZOD_WR_BASE + {3'b000, wr_code};
   wire [5:0] ap_delay  = wr_cycles + {1'b0, ctrl[4:0]};
   wire       fast_exit = mode_reg_zero[`SMRZOD_Z_PDX];

   // decoded fields of register one
   wire [1:0] lat_code  = mode_reg_one[`SMRZOD_O_LAT_HI:`SMRZOD_O_LAT_LO];
   wire [5:0] add_lat   = (lat_code == 2'b01) ? col_delay - 6'h01 :
                          (lat_code == 2'b10) ? col_delay - 6'h02 :
                          6'h00;
   wire [5:0] rd_delay  = add_lat + col_delay;
   wire [5:0] wr_delay  = add_lat + {1'b0, ctrl[9:5]};
   wire       dll_en    = ~mode_reg_one[`SMRZOD_O_DLLDIS];
   wire       qoff      = mode_reg_one[`SMRZOD_O_QOFF];

   // loop stops in self refresh, and in slow-exit precharge power-down
   wire dll_run = dll_en & ~self_ref & ~(pdown & ~fast_exit);

   // chop choice of the command now on the pins
   wire cmd_chop = bl_chop | (bl_otf & ~cmd.addr[`SMRZOD_OTF_BIT]);

   // beat scheduling
   wire start_burst = (state == smrzod_pkg::SMRZOD_WAIT) & ck_rise &
                      (wait_cnt <= 6'h01);
   wire emit_now    = start_burst |
                      ((state == smrzod_pkg::SMRZOD_BURST) & ck_edge);
   wire [2:0] idx   = (state == smrzod_pkg::SMRZOD_WAIT) ? 3'h0 : beat_idx;

   wire [2:0] seq_col  = {start_col[2] ^ idx[2],
                          start_col[1:0] + idx[1:0]};
   wire [2:0] ilv_col  = start_col ^ idx;
   wire [1:0] chop_low = interleave ? start_col[1:0] ^ idx[1:0] :
                         start_col[1:0] + idx[1:0];
   wire [2:0] rd_col   = chop ? {start_col[2], chop_low} :
                         interleave ? ilv_col : seq_col;
   wire [2:0] wr_col   = chop ? {start_col[2], idx[1:0]} : idx;
   wire       beat_off = chop & idx[2];
   wire [2:0] ref_beat = chop_fixed ? `SMRZOD_CHOP_LAST : `SMRZOD_LAST_BEAT;

   // register bus decode
   wire       wb_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire       sel_zro = wb_adr_in == `SMRZOD_ADR_ZERO;
   wire       sel_one = wb_adr_in == `SMRZOD_ADR_ONE;
   wire       sel_st  = wb_adr_in == `SMRZOD_ADR_STAT;
   wire       sel_ct  = wb_adr_in == `SMRZOD_ADR_CTRL;
   wire       ctrl_wr = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & sel_ct;
   wire [9:0] ctrl_nx = {wb_sel_in[1] ? wb_dat_in[9:8] : ctrl[9:8],
                         wb_sel_in[0] ? wb_dat_in[7:0] : ctrl[7:0]};
   wire [31:0] stat_word = {2'b00, dll_rst_pend, self_ref, dll_run,
                            dll_locked_out, ap_delay, wr_cycles[4:0],
                            rd_delay[4:0], add_lat[4:0], col_delay[4:0]};
   wire [31:0] rd_word = sel_zro ? {19'h00000, mode_reg_zero} :
                         sel_one ? {19'h00000, mode_reg_one} :
                         sel_st  ? stat_word :
                         sel_ct  ? {22'h000000, ctrl} : 32'h00000000;

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         ck_d <= 1'b0;
      else
         ck_d <= ck_s;
   end

   // mode register zero; a new load wins over the self-clear
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mode_reg_zero <= `SMRZOD_MR_RST;
         dll_rst_pend  <= 1'b0;
      end
      else if (load_zero)
      begin
         mode_reg_zero <= cmd.addr;
         dll_rst_pend  <= cmd.addr[`SMRZOD_Z_DLLRST];
      end
      else if (dll_rst_pend)
      begin
         mode_reg_zero[`SMRZOD_Z_DLLRST] <= 1'b0;
         dll_rst_pend  <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         mode_reg_one <= `SMRZOD_MR_RST;
      else if (load_one)
         mode_reg_one <= cmd.addr;
   end

   // lock counter runs in link clocks while the loop runs
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         lock_cnt <= `SMRZOD_LOCK_CK;
      else if (dll_rst_pend | ~dll_en)
         lock_cnt <= `SMRZOD_LOCK_CK;
      else if (ck_rise & dll_run & (lock_cnt != 10'h000))
         lock_cnt <= lock_cnt - 10'h001;
   end

   // self refresh: refresh taken with clock enable low, left on cke high
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         self_ref <= 1'b0;
         pdown    <= 1'b0;
      end
      else if (ck_rise)
      begin
         self_ref <= cmd.cke ? 1'b0 : (self_ref | is_ref);
         pdown    <= ~cmd.cke & ~is_ref & ~self_ref;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
         ctrl <= `SMRZOD_CTRL_RST;
      else if (ctrl_wr)
         ctrl <= ctrl_nx;
   end

   // read and write commands that arrive during a burst are ignored
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state      <= smrzod_pkg::SMRZOD_IDLE;
         wait_cnt   <= 6'h00;
         beat_idx   <= 3'h0;
         start_col  <= 3'h0;
         is_write   <= 1'b0;
         chop       <= 1'b0;
         chop_fixed <= 1'b0;
         interleave <= 1'b0;
      end
      else
      begin
         case (state)
            smrzod_pkg::SMRZOD_IDLE:
            begin
               if (is_rd | is_wr)
               begin
                  state      <= smrzod_pkg::SMRZOD_WAIT;
                  wait_cnt   <= is_wr ? wr_delay : rd_delay;
                  start_col  <= cmd.addr[2:0];
                  is_write   <= is_wr;
                  chop       <= cmd_chop;
                  chop_fixed <= bl_chop;
                  interleave <= bt_ilv;
               end
            end
            smrzod_pkg::SMRZOD_WAIT:
            begin
               if (start_burst)
               begin
                  state    <= smrzod_pkg::SMRZOD_BURST;
                  beat_idx <= 3'h1;
               end
               else if (ck_rise)
                  wait_cnt <= wait_cnt - 6'h01;
            end
            smrzod_pkg::SMRZOD_BURST:
            begin
               if (ck_edge)
               begin
                  beat_idx <= beat_idx + 3'h1;
                  if (beat_idx == `SMRZOD_LAST_BEAT)
                     state <= smrzod_pkg::SMRZOD_IDLE;
               end
            end
            default:
               state <= smrzod_pkg::SMRZOD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         beat_valid_out <= 1'b0;
         beat_col_out   <= 3'h0;
         beat_write_out <= 1'b0;
         beat_drive_out <= 1'b0;
         beat_care_out  <= 1'b0;
         write_ref_out  <= 1'b0;
      end
      else
      begin
         beat_valid_out <= emit_now;
         beat_col_out   <= emit_now ? (is_write ? wr_col : rd_col) : 3'h0;
         beat_write_out <= emit_now & is_write;
         beat_drive_out <= emit_now & ~is_write & ~beat_off & ~qoff;
         beat_care_out  <= emit_now & ~beat_off;
         write_ref_out  <= emit_now & is_write & (idx == ref_beat);
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dll_running_out  <= 1'b0;
         dll_locked_out   <= 1'b0;
         self_refresh_out <= 1'b0;
      end
      else
      begin
         dll_running_out  <= dll_run;
         dll_locked_out   <= dll_run & (lock_cnt == 10'h000) & ~dll_rst_pend;
         self_refresh_out <= self_ref;
      end
   end

   // one wait state: ack a cycle after the strobe, dropped the next
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end
      else
      begin
         wb_ack_out <= wb_req;
         wb_dat_out <= wb_req ? rd_word : 32'h00000000;
      end
   end
endmodule : smrzod_decode
`default_nettype wire

// file: smrzod_decode_checker.sv
// concurrent checks on the ports of the mode register decoder
`timescale 1ns/100ps
`default_nettype none
module smrzod_decode_checker (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [31:0] wb_dat_out,
   input  wire logic        wb_ack_out,
   input  wire logic        beat_valid_out,
   input  wire logic [2:0]  beat_col_out,
   input  wire logic        beat_write_out,
   input  wire logic        beat_drive_out,
   input  wire logic        beat_care_out,
   input  wire logic        write_ref_out,
   input  wire logic        dll_running_out,
   input  wire logic        self_refresh_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   sequence req_s;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence pulse_s;
      wb_ack_out ##1 !wb_ack_out;
   endsequence

   bus_answer_a: assert property (req_s |=> pulse_s)
      else $error("bus request not answered after one cycle");
   ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
      else $error("acknowledge without a request");
   idle_data_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
      else $error("read data not zero outside acknowledge");
   unmapped_read_a: assert property (wb_ack_out && !$past(wb_we_in)
      && $past(wb_adr_in) > 8'h0f |-> wb_dat_out == 32'h0)
      else $error("unmapped read returned data");
   col_idle_a: assert property (!beat_valid_out |-> beat_col_out == 3'h0)
      else $error("column shown outside a beat");
   beat_pulse_a: assert property (beat_valid_out |=> !beat_valid_out)
      else $error("beat longer than one cycle");
   drive_read_a: assert property (beat_drive_out |->
      beat_valid_out && !beat_write_out)
      else $error("drivers on outside a read beat");
   care_beat_a: assert property (beat_care_out |-> beat_valid_out)
      else $error("care flag outside a beat");
   write_ref_a: assert property (write_ref_out |->
      beat_valid_out && beat_write_out && beat_col_out[1:0] == 2'h3)
      else $error("write reference outside a write beat");
   refresh_loop_a: assert property (self_refresh_out |->
      !dll_running_out)
      else $error("loop running in self refresh");
endmodule : smrzod_decode_checker
`default_nettype wire

// file: smrzod_ctl_model.sv
// controller model driving command pins with its own link clock
`timescale 1ns/100ps
`default_nettype none
module smrzod_ctl_model (
   output var logic        ck_out,
   output var logic        cke_out,
   output var logic        cs_n_out,
   output var logic        ras_n_out,
   output var logic        cas_n_out,
   output var logic        we_n_out,
   output var logic [2:0]  ba_out,
   output var logic [12:0] addr_out
);
   initial
   begin
      ck_out = 1'b0;
      cke_out = 1'b1;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
      ba_out = 3'h0;
      addr_out = 13'h0;
   end

   // clock rests low between frames; 3 ns offset keeps it off clk edges
   task automatic issue(input logic cke, input logic [3:0] cmd,
                        input logic [2:0] bank, input logic [12:0] adr,
                        input int rises);
      #3;
      cke_out = cke;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd;
      ba_out = bank;
      addr_out = adr;
      #80 ck_out = 1'b1;
      #80 ck_out = 1'b0;
      // deselected pins flip so a stale address never passes for valid
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
      ba_out = ~bank;
      addr_out = ~adr;
      repeat (rises)
      begin
         #80 ck_out = 1'b1;
         #80 ck_out = 1'b0;
      end
   endtask : issue
endmodule : smrzod_ctl_model
`default_nettype wire

// file: smrzod_decode_test.sv
// self-checking bench for the mode register decoder
`timescale 1ns/100ps
`default_nettype none
module smrzod_decode_test;
   logic clk_sys_in, rst_in, ck, cke, cs_n, ras_n, cas_n, we_n;
   logic wb_cyc, wb_stb, wb_we, wb_ack_out;
   logic [2:0] ba;
   logic [12:0] addr;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_dat_out;
   logic beat_valid_out, beat_write_out, beat_drive_out, beat_care_out;
   logic write_ref_out, dll_running_out, dll_locked_out, self_refresh_out;
   logic [2:0] beat_col_out;
   logic [7:0] bq[$];
   int err_total = 0;
   int checks_done = 0;
   int cyc_n = 0;

   smrzod_ctl_model u_ctl (.ck_out(ck), .cke_out(cke), .cs_n_out(cs_n),
      .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
      .ba_out(ba), .addr_out(addr));
   smrzod_decode u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ck_in(ck), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n),
      .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
      .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
      .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .beat_valid_out(beat_valid_out), .beat_col_out(beat_col_out),
      .beat_write_out(beat_write_out), .beat_drive_out(beat_drive_out),
      .beat_care_out(beat_care_out), .write_ref_out(write_ref_out),
      .dll_running_out(dll_running_out), .dll_locked_out(dll_locked_out),
      .self_refresh_out(self_refresh_out));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in)
   begin
      cyc_n <= cyc_n + 1;
      if (beat_valid_out === 1'b1)
         bq.push_back({beat_write_out, beat_drive_out, beat_care_out,
                       write_ref_out, 1'b0, beat_col_out});
      // the whole run needs about 5500 cycles
      if (cyc_n == 40000)
      begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys_in);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'h3, we, adr, wd};
      @(posedge clk_sys_in);
      while (wb_ack_out !== 1'b1)
         @(posedge clk_sys_in);
      rd = wb_dat_out;
      {wb_cyc, wb_stb} <= 2'h0;
   endtask : wb

   task automatic burst(input logic [3:0] cmd, input logic [12:0] adr,
                        input logic [23:0] cols, input logic [7:0] drv,
                        input logic [7:0] care, input logic [7:0] wref,
                        input int n);
      bq.delete();
      u_ctl.issue(1'b1, cmd, 3'h0, adr, 14);
      repeat (8) @(posedge clk_sys_in);
      chk(bq.size(), 8);
      for (int i = 0; i < 8; i++)
      begin
         chk(bq[i][7:4], {~cmd[0], drv[7-i], care[7-i], wref[7-i]});
         if (i < n)
            chk(bq[i][2:0], cols[23-3*i -: 3]);
      end
   endtask : burst

   task automatic t_reset_regs();
      logic [31:0] rd;
      wb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0000_00a6);
      wb(1'b1, 8'h00, 32'h0000_1fff, rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      chk(rd, 32'h0);
      wb(1'b0, 8'h10, 32'h0, rd);
      chk(rd, 32'h0);
      wb(1'b1, 8'h0c, 32'h0000_00a7, rd);
      wb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0000_00a7);
      // only the low byte lane enabled: bits 9:8 must keep their value
      wb_sel <= 4'h1;
      wb(1'b1, 8'h0c, 32'h0000_03a7, rd);
      wb_sel <= 4'hf;
      wb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0000_00a7);
   endtask : t_reset_regs

   task automatic t_load_lock();
      logic [31:0] rd;
      // no leveling, no termination, reserved bits low
      u_ctl.issue(1'b1, 4'h0, 3'h1, 13'h0008, 4);
      // loop reset, then the full lock time before any read
      u_ctl.issue(1'b1, 4'h0, 3'h0, 13'h1110, 520);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h0000_0008);
      wb(1'b0, 8'h00, 32'h0, rd);
      chk(rd, 32'h0000_1010);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk(rd[29:0], {4'h3, 6'h17, 5'h10, 5'h09, 5'h04, 5'h05});
   endtask : t_load_lock

   task automatic t_bursts();
      burst(4'h5, 13'h0001, 24'h298bbc, 8'hff, 8'hff, 8'h00, 8);
      u_ctl.issue(1'b1, 4'h0, 3'h0, 13'h1018, 4);
      burst(4'h5, 13'h0001, 24'h21ab3e, 8'hff, 8'hff, 8'h00, 8);
      u_ctl.issue(1'b1, 4'h0, 3'h0, 13'h1019, 4);
      burst(4'h5, 13'h0005, 24'hb3e000, 8'hf0, 8'hf0, 8'h00, 4);
      burst(4'h4, 13'h1005, 24'h053977, 8'h00, 8'hff, 8'h01, 8);
      u_ctl.issue(1'b1, 4'h0, 3'h0, 13'h101a, 4);
      burst(4'h4, 13'h0006, 24'h977000, 8'h00, 8'hf0, 8'h10, 4);
      u_ctl.issue(1'b1, 4'h0, 3'h1, 13'h1008, 4);
      burst(4'h5, 13'h0001, 24'h21a000, 8'h00, 8'hf0, 8'h00, 4);
   endtask : t_bursts

   task automatic t_power();
      logic [31:0] rd;
      for (int p = 0; p < 2; p++)
      begin
         u_ctl.issue(1'b1, 4'h0, 3'h0, {p[0], 12'h010}, 4);
         u_ctl.issue(1'b0, 4'hf, 3'h0, 13'h0, 2);
         repeat (4) @(posedge clk_sys_in);
         chk(dll_running_out, p[0]);
         u_ctl.issue(1'b1, 4'hf, 3'h0, 13'h0, 2);
      end
      u_ctl.issue(1'b0, 4'h1, 3'h0, 13'h0, 2);
      repeat (4) @(posedge clk_sys_in);
      chk({self_refresh_out, dll_running_out}, 2'h2);
      u_ctl.issue(1'b1, 4'hf, 3'h0, 13'h0, 2);
      repeat (4) @(posedge clk_sys_in);
      chk({self_refresh_out, dll_running_out}, 2'h1);
      // added latency of delay minus two, delay code with bit 2, recovery code 5 (10 cycles)
      u_ctl.issue(1'b1, 4'h0, 3'h1, 13'h0010, 4);
      u_ctl.issue(1'b1, 4'h0, 3'h0, 13'h0a14, 4);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk(rd[29:0], {4'h3, 6'h11, 5'h0a, 5'h18, 5'h0b, 5'h0d});
   endtask : t_power

   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      wb_sel = 4'hf;
      rst_in = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reset_regs();
      t_load_lock();
      t_bursts();
      t_power();
      end_of_test();
   end
endmodule : smrzod_decode_test

bind smrzod_decode smrzod_decode_checker u_chk (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .beat_valid_out(beat_valid_out), .beat_col_out(beat_col_out),
   .beat_write_out(beat_write_out), .beat_drive_out(beat_drive_out),
   .beat_care_out(beat_care_out), .write_ref_out(write_ref_out),
   .dll_running_out(dll_running_out), .self_refresh_out(self_refresh_out));
`default_nettype wire
